// >>> inc/mkg_pkg.sv
/*
 * mkg_pkg: shared constants, register map, field layout and types of the
 * four-channel marker signal generator.
 * Assumes: imported whole by every design file of the block.
 */
package mkg_pkg;

	// ----------------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CH_W = 2;
	localparam int CNT_W = 16;
	localparam int PAT_W = 32;
	localparam int PLEN_W = 5;
	localparam int IDX_W = 15;
	localparam int ADDR_W = 12;
	localparam int LIST_N = 8;
	localparam int LSEL_W = 3;

	// ----------------------------------------------------------------------
	// modes and ratio phase
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		MKG_PASS = 3'h0,
		MKG_RESTART = 3'h1,
		MKG_DIVIDE = 3'h2,
		MKG_PATTERN = 3'h3,
		MKG_RATIO = 3'h4,
		MKG_LIST = 3'h5
	} mkg_mode_t;

	typedef enum logic {
		MKG_RAT_ON = 1'b0,
		MKG_RAT_OFF = 1'b1
	} mkg_phase_t;

	// ----------------------------------------------------------------------
	// register map: one 32-byte block per channel, then globals
	// ----------------------------------------------------------------------
	localparam logic [2:0] REG_MODE = 3'h0;
	localparam logic [2:0] REG_DIV = 3'h1;
	localparam logic [2:0] REG_PAT = 3'h2;
	localparam logic [2:0] REG_PLEN = 3'h3;
	localparam logic [2:0] REG_ON = 3'h4;
	localparam logic [2:0] REG_OFF = 3'h5;
	localparam logic [2:0] REG_LSEL = 3'h6;
	localparam logic [2:0] REG_LDATA = 3'h7;
	localparam int REG_LSB = 2;
	localparam int CH_LSB = 5;
	localparam int BLK_LSB = 7;
	localparam logic [ADDR_W-1:0] A_STATUS = 12'h080;
	localparam logic [ADDR_W-1:0] A_INDEX = 12'h084;

	// reset values and lower limits
	localparam logic [CNT_W-1:0] DIV_RST = 16'h0002;
	localparam logic [CNT_W-1:0] MIN_DIV = 16'h0002;
	localparam logic [CNT_W-1:0] LEN_RST = 16'h0001;
	localparam logic [CNT_W-1:0] MIN_LEN = 16'h0001;
	localparam logic [PLEN_W-1:0] PLEN_RST = 5'h1F;

	// list entry layout: enable, level, last index, first index
	localparam int LE_START_LSB = 0;
	localparam int LE_END_LSB = 15;
	localparam int LE_LEVEL = 30;
	localparam int LE_ENA = 31;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// clamp a programmed count to its smallest usable value
	function automatic logic [CNT_W-1:0] mkg_at_least(input logic [CNT_W-1:0] val, input logic [CNT_W-1:0] low);
		return (val < low) ? low : val;
	endfunction : mkg_at_least

endpackage : mkg_pkg

// >>> verilog/mkg_list.sv
/*
 * mkg_list: index/range table of one marker channel, matched in parallel
 * against the current sample index; read port is registered.
 * Assumes: sample index and writes come from the sample clock domain.
 */
`timescale 1ns/100ps
module mkg_list import mkg_pkg::*; #(
	parameter int N = LIST_N
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [LSEL_W-1:0] sel,
	input wire logic [31:0] wr_data,
	input wire logic [IDX_W-1:0] idx,
	output logic [31:0] rd_data,
	output logic level
);
	logic [31:0] entry [N];
	logic [N-1:0] hit;

	// table store, cleared at reset so no stale entry can match
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int e = 0; e < N; e++) begin
				entry[e] <= 32'h0000_0000;
			end
		end else if (wr_en) begin
			entry[sel] <= wr_data;
		end
	end

	// registered read back of the selected entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= entry[sel];
		end
	end

	// inclusive range compare per entry; a single index has first == last
	for (genvar e = 0; e < N; e++) begin : g_hit
		assign hit[e] = entry[e][LE_ENA] && idx >= entry[e][LE_START_LSB +: IDX_W]
			&& idx <= entry[e][LE_END_LSB +: IDX_W];
	end

	// lowest entry wins on overlap; uncovered index reads low
	always_comb begin
		level = 1'b0;
		for (int e = N - 1; e >= 0; e--) begin
			if (hit[e]) begin
				level = entry[e][LE_LEVEL];
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	uncovered_low_a: assert property (hit == '0 |-> !level) else $error("uncovered index not low");
	first_entry_a: assert property (hit[0] |-> level == entry[0][LE_LEVEL]) else $error("entry level lost");

endmodule : mkg_list

// >>> verilog/mkg_chan.sv
/*
 * mkg_chan: per-channel marker waveform engine with registered output.
 * Assumes: one clk edge per sample; restart is a one-cycle pulse at the
 * first sample of a waveform or segment.
 */
`timescale 1ns/100ps
module mkg_chan import mkg_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire mkg_mode_t mode,
	input wire logic [CNT_W-1:0] divider,
	input wire logic [PAT_W-1:0] pattern,
	input wire logic [PLEN_W-1:0] pat_last,
	input wire logic [CNT_W-1:0] on_len,
	input wire logic [CNT_W-1:0] off_len,
	input wire logic restart,
	input wire logic trace,
	input wire logic list_level,
	output logic level
);
	logic [CNT_W-1:0] div_cnt;
	logic [CNT_W-1:0] div_eff;
	logic [PLEN_W-1:0] bit_idx;
	logic [PLEN_W-1:0] cur_bit;
	logic [CNT_W-1:0] rat_cnt;
	logic [CNT_W-1:0] cur_rcnt;
	logic [CNT_W-1:0] rat_len;
	mkg_phase_t rat_phase;
	mkg_phase_t cur_phase;
	logic next_level;

	// divider below two would exceed half the sample rate, so clamp it
	assign div_eff = mkg_at_least(divider, MIN_DIV);

	// free-running divider; not realigned on restart, so strobes keep
	// their spacing of at least two samples across a restart
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt <= '0;
		end else if (div_cnt >= div_eff - CNT_W'(1)) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + CNT_W'(1);
		end
	end

	// pattern pointer, bit 0 first, wraps after the last programmed bit
	assign cur_bit = restart ? '0 : bit_idx;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_idx <= '0;
		end else if (cur_bit == pat_last) begin
			bit_idx <= '0;
		end else begin
			bit_idx <= cur_bit + PLEN_W'(1);
		end
	end

	// ratio: on interval then off interval, each at least one sample
	assign cur_phase = restart ? MKG_RAT_ON : rat_phase;
	assign cur_rcnt = restart ? '0 : rat_cnt;
	assign rat_len = (cur_phase == MKG_RAT_ON) ? mkg_at_least(on_len, MIN_LEN) : mkg_at_least(off_len, MIN_LEN);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rat_cnt <= '0;
			rat_phase <= MKG_RAT_ON;
		end else if (cur_rcnt >= rat_len - CNT_W'(1)) begin
			rat_cnt <= '0;
			rat_phase <= (cur_phase == MKG_RAT_ON) ? MKG_RAT_OFF : MKG_RAT_ON;
		end else begin
			rat_cnt <= cur_rcnt + CNT_W'(1);
			rat_phase <= cur_phase;
		end
	end

	// output select; the stored trace is only read, never altered
	always_comb begin
		case (mode)
			MKG_PASS: next_level = trace;
			MKG_RESTART: next_level = restart;
			MKG_DIVIDE: next_level = (div_cnt == '0);
			MKG_PATTERN: next_level = pattern[cur_bit];
			MKG_RATIO: next_level = (cur_phase == MKG_RAT_ON);
			MKG_LIST: next_level = list_level;
			default: next_level = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= 1'b0;
		end else begin
			level <= next_level;
		end
	end

endmodule : mkg_chan

// >>> verilog/mkg_top.sv
/*
 * mkg_top: four-channel marker signal generator with AXI4-Lite registers.
 * Assumes: clk is the sample clock (one edge per sample); wave_marker and
 * play_start come from the playback engine on the same clock.
 */
// Decided for this implementation: the AXI4-Lite register port and the address map.
// Overview of operation
// - each channel picks its own mode that drives its marker output
// - pass mode outputs the stored waveform marker trace unchanged
// - other modes override only the output, never the stored trace
// - restart mode pulses when waveform or segment playback begins
// - divider mode strobes at sample rate over the programmed divider
// - strobe rate never exceeds half the sample rate; divider minimum two
// - pattern mode holds a programmable pattern of up to 32 bits
// - a one bit drives the output high, a zero bit low
// - ratio mode holds high for on samples, then low for off samples
// - one ratio period is one high then one low interval, repeating
// - list mode drives the level given to each listed index or range
`timescale 1ns/100ps
module mkg_top import mkg_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [NUM_CH-1:0] wave_marker,
	input wire logic play_start,
	output logic [NUM_CH-1:0] marker_out
);

	// ----------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------
	logic [ADDR_W-1:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic wr_fire;
	logic wr_chan;
	logic [CH_W-1:0] wr_ch;
	logic [2:0] wr_reg;
	logic [CH_W-1:0] rd_ch;
	logic [31:0] rd_mux;
	logic [IDX_W-1:0] idx;
	logic [IDX_W-1:0] cur_idx;
	mkg_mode_t mode_r [NUM_CH];
	logic [CNT_W-1:0] div_r [NUM_CH];
	logic [PAT_W-1:0] pat_r [NUM_CH];
	logic [PLEN_W-1:0] plen_r [NUM_CH];
	logic [CNT_W-1:0] on_r [NUM_CH];
	logic [CNT_W-1:0] off_r [NUM_CH];
	logic [LSEL_W-1:0] lsel_r [NUM_CH];
	logic [31:0] list_rd [NUM_CH];
	logic [NUM_CH-1:0] list_we;
	logic [NUM_CH-1:0] list_lvl;

	// byte-lane merge for partial writes
	function automatic logic [31:0] mkg_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction : mkg_merge

	// whole channel blocks plus the two global words are mapped
	function automatic logic mkg_mapped(input logic [ADDR_W-1:0] a);
		return (a[ADDR_W-1:BLK_LSB] == '0) || a == A_STATUS || a == A_INDEX;
	endfunction : mkg_mapped

	// ----------------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------------
	// address and data latch independently; write once both are held
	assign wr_fire = !awready && !wready && !bvalid;
	assign wr_chan = (aw_q[ADDR_W-1:BLK_LSB] == '0);
	assign wr_ch = aw_q[CH_LSB +: CH_W];
	assign wr_reg = aw_q[REG_LSB +: 3];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			aw_q <= '0;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_q <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_q <= wdata;
				ws_q <= wstrb;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= mkg_mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------------
	// channel configuration registers
	// ----------------------------------------------------------------------
	// mode codes outside the table fall to a quiet low output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < NUM_CH; c++) begin
				mode_r[c] <= MKG_PASS;
				div_r[c] <= DIV_RST;
				pat_r[c] <= 32'h0000_0000;
				plen_r[c] <= PLEN_RST;
				on_r[c] <= LEN_RST;
				off_r[c] <= LEN_RST;
				lsel_r[c] <= '0;
			end
		end else if (wr_fire && wr_chan) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (wr_ch == CH_W'(c)) begin
					case (wr_reg)
						REG_MODE: mode_r[c] <= mkg_mode_t'(3'(mkg_merge(32'(mode_r[c]), w_q, ws_q)));
						REG_DIV: div_r[c] <= CNT_W'(mkg_merge(32'(div_r[c]), w_q, ws_q));
						REG_PAT: pat_r[c] <= mkg_merge(pat_r[c], w_q, ws_q);
						REG_PLEN: plen_r[c] <= PLEN_W'(mkg_merge(32'(plen_r[c]), w_q, ws_q));
						REG_ON: on_r[c] <= CNT_W'(mkg_merge(32'(on_r[c]), w_q, ws_q));
						REG_OFF: off_r[c] <= CNT_W'(mkg_merge(32'(off_r[c]), w_q, ws_q));
						REG_LSEL: lsel_r[c] <= LSEL_W'(mkg_merge(32'(lsel_r[c]), w_q, ws_q));
						default: ;
					endcase
				end
			end
		end
	end

	// list entry writes go straight into the selected table slot
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			list_we[c] = wr_fire && wr_chan && wr_ch == CH_W'(c) && wr_reg == REG_LDATA;
		end
	end

	// ----------------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------------
	assign rd_ch = araddr[CH_LSB +: CH_W];

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (araddr == A_STATUS) begin
			rd_mux = 32'(marker_out);
		end else if (araddr == A_INDEX) begin
			rd_mux = 32'(idx);
		end else if (araddr[ADDR_W-1:BLK_LSB] == '0) begin
			case (araddr[REG_LSB +: 3])
				REG_MODE: rd_mux = 32'(mode_r[rd_ch]);
				REG_DIV: rd_mux = 32'(div_r[rd_ch]);
				REG_PAT: rd_mux = pat_r[rd_ch];
				REG_PLEN: rd_mux = 32'(plen_r[rd_ch]);
				REG_ON: rd_mux = 32'(on_r[rd_ch]);
				REG_OFF: rd_mux = 32'(off_r[rd_ch]);
				REG_LSEL: rd_mux = 32'(lsel_r[rd_ch]);
				default: rd_mux = list_rd[rd_ch];
			endcase
		end
	end

	// one read at a time; data captured with the address handshake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= mkg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// sample index and channels
	// ----------------------------------------------------------------------
	// index is zero on the restart sample; saturates so that list entries
	// never alias on very long waveforms
	assign cur_idx = play_start ? '0 : idx;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idx <= '0;
		end else if (cur_idx != '1) begin
			idx <= cur_idx + IDX_W'(1);
		end else begin
			idx <= cur_idx;
		end
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		mkg_list u_list (
			.clk(clk),
			.rst(rst),
			.wr_en(list_we[c]),
			.sel(lsel_r[c]),
			.wr_data(mkg_merge(list_rd[c], w_q, ws_q)),
			.idx(cur_idx),
			.rd_data(list_rd[c]),
			.level(list_lvl[c])
		);
		mkg_chan u_chan (
			.clk(clk),
			.rst(rst),
			.mode(mode_r[c]),
			.divider(div_r[c]),
			.pattern(pat_r[c]),
			.pat_last(plen_r[c]),
			.on_len(on_r[c]),
			.off_len(off_r[c]),
			.restart(play_start),
			.trace(wave_marker[c]),
			.list_level(list_lvl[c]),
			.level(marker_out[c])
		);
	end

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	// cycles since the last register write, for config-stable checks
	logic [19:0] cfg_age;
	logic [CNT_W:0] gap_cnt [NUM_CH];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_age <= '0;
		end else if (wr_fire) begin
			cfg_age <= '0;
		end else if (cfg_age != '1) begin
			cfg_age <= cfg_age + 20'h0_0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < NUM_CH; c++) begin
				gap_cnt[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				gap_cnt[c] <= marker_out[c] ? (CNT_W+1)'(1) : gap_cnt[c] + (CNT_W+1)'(1);
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
	read_answer_a: assert property (arvalid && arready |=> rvalid && !arready) else $error("read not answered");
	// a held read answer may not change while the master stalls
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer changed while held");
	// the write lands the edge after both halves are held, answered on that same edge
	write_answer_a: assert property (wr_fire |=> bvalid) else $error("write not answered");
	// a second request must wait for the answer handshake
	ready_low_a: assert property (bvalid |-> !awready && !wready) else $error("write taken while answer pending");
	read_busy_a: assert property (rvalid |-> !arready) else $error("read taken while answer pending");
	// unmapped writes are dropped and refused with an error code
	write_err_a: assert property (wr_fire && !mkg_mapped(aw_q) |=> bresp == RESP_SLVERR)
		else $error("unmapped write not refused");

	// ----------------------------------------------------------------------
	// sample index checks
	// ----------------------------------------------------------------------
	// index is one after the restart edge, then steps once per sample
	sequence idx_restart_seq;
		idx == IDX_W'(1) ##1 idx == IDX_W'(2);
	endsequence
	index_restart_a: assert property (play_start ##1 !play_start |-> idx_restart_seq)
		else $error("index not restarted");
	index_step_a: assert property (!play_start && idx != '1 |=> idx == $past(idx) + IDX_W'(1))
		else $error("index step wrong");
	// saturation keeps late samples clear of the start of the table
	index_hold_a: assert property (!play_start && idx == '1 |=> idx == '1)
		else $error("index wrapped");
	// the index word reads the count live at the address edge
	index_read_a: assert property (arvalid && arready && araddr == A_INDEX |=> rdata == 32'($past(idx)))
		else $error("index word wrong");

	for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
		sequence rat_seq;
			marker_out[c] [*2] ##1 !marker_out[c] [*3] ##1 marker_out[c];
		endsequence
		sequence pat_seq;
			marker_out[c] == pat_r[c][0] ##1 marker_out[c] == pat_r[c][1];
		endsequence

		pass_through_a: assert property (mode_r[c] == MKG_PASS |=> marker_out[c] == $past(wave_marker[c]))
			else $error("pass mode altered trace");
		restart_pulse_a: assert property (mode_r[c] == MKG_RESTART |=> marker_out[c] == $past(play_start))
			else $error("restart pulse wrong");
		div_half_rate_a: assert property ($past(mode_r[c]) == MKG_DIVIDE && mode_r[c] == MKG_DIVIDE && marker_out[c]
			|=> !marker_out[c]) else $error("strobe above half rate");
		div_period_a: assert property (mode_r[c] == MKG_DIVIDE && cfg_age > {3'h0, mkg_at_least(div_r[c], MIN_DIV), 1'b0}
			&& marker_out[c] |-> gap_cnt[c] == {1'b0, mkg_at_least(div_r[c], MIN_DIV)}) else $error("strobe period wrong");
		pattern_walk_a: assert property (mode_r[c] == MKG_PATTERN && plen_r[c] != '0 && play_start && !wr_fire
			|=> pat_seq) else $error("pattern bit order wrong");
		ratio_period_a: assert property (mode_r[c] == MKG_RATIO && on_r[c] == 16'h0002 && off_r[c] == 16'h0003
			&& play_start |=> (!play_start && !wr_fire) throughout rat_seq)
			else $error("ratio on/off lengths wrong");
		list_follow_a: assert property (mode_r[c] == MKG_LIST |=> marker_out[c] == $past(list_lvl[c]))
			else $error("list level not driven");
		// codes past the table give a quiet output rather than a stale one
		bad_mode_low_a: assert property (mode_r[c] > MKG_LIST |=> !marker_out[c])
			else $error("unused mode code not low");
	end

endmodule : mkg_top

// >>> tb/mkg_marker_sink.sv
/*
 * mkg_marker_sink: model of the equipment that receives the four marker
 * outputs; counts the high samples seen on each channel.
 * Assumes: markers are sampled on the sample clock, clr empties the counts.
 */
`timescale 1ns/100ps
module mkg_marker_sink import mkg_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic [NUM_CH-1:0] marker,
	output logic [NUM_CH*16-1:0] highs
);
	// ----------------------------------------------------------------------
	// high sample counters
	// ----------------------------------------------------------------------
	// one count per channel; a receiver only sees levels, never the setup
	always_ff @(posedge clk or posedge rst) begin
		for (int c = 0; c < NUM_CH; c++) begin
			if (rst || clr) begin
				highs[c*16 +: 16] <= 16'h0000;
			end else if (marker[c]) begin
				highs[c*16 +: 16] <= highs[c*16 +: 16] + 16'h0001;
			end
		end
	end
endmodule : mkg_marker_sink

// >>> tb/test_marker_signal_generator.sv
/*
 * test_marker_signal_generator: register-level bench of the marker generator.
 * Assumes: AXI4-Lite master tasks below, sink model on the marker outputs.
 */
`timescale 1ns/100ps
module test_marker_signal_generator import mkg_pkg::*; ;
	logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, play_start = 0, clr = 0;
	logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0] wstrb = 0, wave_marker = 0, marker_out;
	logic [1:0] bresp, rresp, rsp;
	logic [NUM_CH*16-1:0] highs;
	logic [NUM_CH-1:0] obs [12];
	int err_count = 0, num_checks = 0, cyc = 0;

	mkg_top uut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .wave_marker(wave_marker), .play_start(play_start), .marker_out(marker_out));
	mkg_marker_sink sink (.clk(clk), .rst(rst), .clr(clr), .marker(marker_out), .highs(highs));

	// ----------------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------------
	initial begin
		forever #50 clk = ~clk;
	end
	// whole run is under two hundred cycles; generous ceiling
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] ra(input int c, input logic [2:0] r);
		return ADDR_W'(c * 32 + 4 * r);
	endfunction : ra

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// address and data offered together, each released once taken;
	// bready and rready rise only once the answer shows, so it must be held
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1;
		end while (!(bvalid === 1'b1 && bready === 1'b1));
		rsp = bresp;
		bready <= 0;
	endtask : axi_write

	task automatic axi_read(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
			if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1;
		end while (!(rvalid === 1'b1 && rready === 1'b1));
		rd = rdata;
		rsp = rresp;
		rready <= 0;
	endtask : axi_read

	// start playback and record twelve output samples
	task automatic play();
		@(posedge clk);
		play_start <= 1;
		clr <= 1;
		wave_marker <= 4'h0;
		for (int s = 0; s < 12; s++) begin
			@(posedge clk);
			play_start <= 0;
			clr <= 0;
			wave_marker <= {4{s % 3 == 0}};
			@(negedge clk);
			obs[s] = marker_out;
		end
		@(posedge clk);
		@(negedge clk);
	endtask : play

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		axi_read(ra(0, REG_MODE));
		chk("mode reset", 32'h0000_0000, rd);
		axi_read(ra(1, REG_DIV));
		chk("div reset", 32'h0000_0002, rd);
		axi_read(ra(2, REG_PLEN));
		chk("plen reset", 32'h0000_001F, rd);
		axi_read(12'h100);
		chk("unmapped resp", 32'(RESP_SLVERR), 32'(rsp));
		axi_write(12'h100, 32'h0000_0001);
		chk("unmapped write resp", 32'(RESP_SLVERR), 32'(rsp));
		$display("test reset values done");
		// four channels, four different modes at once
		axi_write(ra(0, REG_MODE), 32'(MKG_RESTART));
		chk("write resp", 32'(RESP_OKAY), 32'(rsp));
		axi_write(ra(1, REG_DIV), 32'h0000_0003);
		axi_write(ra(1, REG_MODE), 32'(MKG_DIVIDE));
		axi_write(ra(2, REG_PAT), 32'h8000_000D);
		axi_read(ra(2, REG_PAT));
		chk("pattern width", 32'h8000_000D, rd);
		axi_write(ra(2, REG_PLEN), 32'h0000_0003);
		axi_write(ra(2, REG_MODE), 32'(MKG_PATTERN));
		axi_write(ra(3, REG_ON), 32'h0000_0002);
		axi_write(ra(3, REG_OFF), 32'h0000_0003);
		axi_write(ra(3, REG_MODE), 32'(MKG_RATIO));
		play();
		for (int s = 0; s < 12; s++) begin
			chk("restart", 32'(s == 0), 32'(obs[s][0]));
			chk("pattern", 32'(4'hD >> (s % 4)) & 32'h1, 32'(obs[s][2]));
			chk("ratio", 32'((s % 5) < 2), 32'(obs[s][3]));
		end
		chk("divider highs", 32'h0000_0004, 32'(highs[31:16]));
		$display("test mixed modes done");
		// ranges written start-end with a level, entries kept separate
		axi_write(ra(1, REG_LSEL), 32'h0000_0000);
		axi_write(ra(1, REG_LDATA), 32'hC002_0002);
		axi_write(ra(1, REG_LSEL), 32'h0000_0001);
		axi_write(ra(1, REG_LDATA), 32'hC003_0006);
		axi_write(ra(1, REG_MODE), 32'(MKG_LIST));
		axi_write(ra(0, REG_MODE), 32'(MKG_PASS));
		axi_write(ra(2, REG_DIV), 32'h0000_0001);
		axi_write(ra(2, REG_MODE), 32'(MKG_DIVIDE));
		axi_write(ra(3, REG_MODE), 32'h0000_0007);
		play();
		for (int s = 0; s < 12; s++) begin
			chk("pass", 32'(s % 3 == 1), 32'(obs[s][0]));
			chk("list", 32'((s >= 2 && s <= 4) || s == 6), 32'(obs[s][1]));
			chk("unused mode", 32'h0000_0000, 32'(obs[s][3]));
		end
		chk("half rate highs", 32'h0000_0006, 32'(highs[47:32]));
		axi_read(A_INDEX);
		chk("sample index", 32'h0000_000E, rd);
		$display("test pass list divider done");
		print_verdict();
	end
endmodule : test_marker_signal_generator
